//--- verilog/dmc_pkg.sv
// Package: register map, encodings, reset values and types of the two-channel DMA controller
package dmc_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int DMC_NCH         = 2;
  localparam int DMC_CH_SEL_BIT  = 5;
  localparam int DMC_SWTRIG_BIT  = 31;
  localparam int DMC_ST_DONE     = 0;
  localparam int DMC_ST_ERR      = 2;

  // ************************************************************
  // Register map (byte addresses, channel n at n * DMC_CH_STRIDE)
  // ************************************************************
  localparam logic [7:0] DMC_CH_STRIDE  = 8'h20;
  localparam logic [7:0] DMC_CH_END     = 8'h40;
  localparam logic [4:0] DMC_OFS_CTRL   = 5'h00;
  localparam logic [4:0] DMC_OFS_SRC    = 5'h04;
  localparam logic [4:0] DMC_OFS_DST    = 5'h08;
  localparam logic [4:0] DMC_OFS_BLK    = 5'h0c;
  localparam logic [4:0] DMC_OFS_REP    = 5'h10;
  localparam logic [4:0] DMC_OFS_CUR    = 5'h14;
  localparam logic [4:0] DMC_OFS_CNT    = 5'h18;
  localparam logic [7:0] DMC_ADR_PRIO   = 8'h40;
  localparam logic [7:0] DMC_ADR_INTST  = 8'h44;
  localparam logic [7:0] DMC_ADR_INTCLR = 8'h48;
  localparam logic [7:0] DMC_ADR_INTEN  = 8'h4c;

  // ************************************************************
  // Field encodings
  // ************************************************************
  localparam logic [1:0]  DMC_TRIG_SW     = 2'h0;
  localparam logic [1:0]  DMC_TRIG_PERIPH = 2'h1;
  localparam logic [1:0]  DMC_TRIG_EVENT  = 2'h2;
  localparam logic [1:0]  DMC_AM_FIXED    = 2'h0;
  localparam logic [1:0]  DMC_AM_INC      = 2'h1;
  localparam logic [1:0]  DMC_AM_DEC      = 2'h2;
  localparam logic [1:0]  DMC_RL_NONE     = 2'h0;
  localparam logic [1:0]  DMC_RL_BURST    = 2'h1;
  localparam logic [1:0]  DMC_RL_BLOCK    = 2'h2;
  localparam logic [1:0]  DMC_RL_TRANS    = 2'h3;
  localparam logic [16:0] DMC_BLK_MAX     = 17'h10000;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {DMC_S_IDLE, DMC_S_RD, DMC_S_WR} dmc_fsm_t;

  typedef struct packed {
    logic [1:0] dreload;
    logic [1:0] sreload;
    logic [1:0] dmode;
    logic [1:0] smode;
    logic       link;
    logic       crc;
    logic       rep;
    logic [1:0] burst;
    logic [1:0] trig;
    logic       en;
  } dmc_ctrl_t;

  typedef struct packed {
    dmc_ctrl_t   ctrl;
    logic [15:0] src;
    logic [15:0] dst;
    logic [15:0] blksz;
    logic [7:0]  repcnt;
    logic [15:0] cur_src;
    logic [15:0] cur_dst;
    logic [16:0] blk_left;
    logic [7:0]  rep_left;
    logic        pend;
    logic        swblk;
  } dmc_chan_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } dmc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } dmc_apb_rsp_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } dmc_mem_req_t;

  typedef struct packed {
    logic       rvalid;
    logic       err;
    logic [7:0] rdata;
  } dmc_mem_rsp_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } dmc_crc_t;

  typedef struct packed {
    dmc_fsm_t                 fsm;
    logic                     act;
    logic                     rr_last;
    logic [3:0]               bcnt;
    logic [7:0]               data;
    dmc_chan_t [DMC_NCH-1:0]  ch;
    logic                     prio;
    logic [3:0]               int_st;
    logic [3:0]               int_en;
    dmc_apb_rsp_t             apb;
    dmc_mem_req_t             mem;
    dmc_crc_t                 crc;
    logic                     irq;
  } dmc_state_t;

  localparam dmc_state_t DMC_STATE_RST = '0;

endpackage

//--- verilog/dmc_top.sv
// Two-channel DMA controller: APB register slave and byte-wide data bus master
`timescale 1ns/1ps
module dmc_top
  import dmc_pkg::*;
(
  input  wire logic               sys_clk_in,
  input  wire logic               sys_rst_in,
  input  wire dmc_apb_req_t       apb_req_in,
  output      dmc_apb_rsp_t       apb_rsp_out,
  output      dmc_mem_req_t       mem_req_out,
  input  wire dmc_mem_rsp_t       mem_rsp_in,
  input  wire logic [DMC_NCH-1:0] periph_req_in,
  input  wire logic [DMC_NCH-1:0] event_in,
  output      dmc_crc_t           crc_out,
  output      logic               irq_out
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [15:0] dmc_step(input logic [15:0] a, input logic [1:0] m);
    logic [15:0] o;
    o = a;
    if (m == DMC_AM_INC) begin
      o = a + 16'h1;
    end else if (m == DMC_AM_DEC) begin
      o = a - 16'h1;
    end
    return o;
  endfunction

  function automatic logic dmc_rl(input logic [1:0] sel, input logic be, input logic ke,
                                  input logic te);
    return ((sel == DMC_RL_BURST) && be) || ((sel == DMC_RL_BLOCK) && ke) ||
           ((sel == DMC_RL_TRANS) && te);
  endfunction

  // Arms a channel: working counters take the programmed start values
  function automatic dmc_chan_t dmc_load(input dmc_chan_t c);
    dmc_chan_t o;
    o          = c;
    o.cur_src  = c.src;
    o.cur_dst  = c.dst;
    o.blk_left = (c.blksz == 16'h0) ? DMC_BLK_MAX : {1'b0, c.blksz};
    o.rep_left = c.repcnt;
    return o;
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  dmc_state_t  r;
  dmc_state_t  n;
  logic        acc;
  logic        wr;
  logic        hit;
  logic        is_ch;
  logic        ci;
  logic [4:0]  ofs;
  logic [31:0] rdv;
  logic [3:0]  st_set;
  logic [3:0]  st_clr;
  logic        rdy0;
  logic        rdy1;
  logic        c_sel;
  logic        a;
  logic [3:0]  blen;
  logic        burst_end;
  logic        blk_end;
  logic        trans_end;

  always_comb begin
    n         = r;
    st_set    = '0;
    st_clr    = '0;
    rdv       = '0;
    hit       = 1'b0;
    rdy0      = 1'b0;
    rdy1      = 1'b0;
    c_sel     = 1'b0;
    blen      = 4'h1;
    burst_end = 1'b0;
    blk_end   = 1'b0;
    trans_end = 1'b0;
    a         = r.act;
    n.crc.valid = 1'b0;

    // ************************************************************
    // APB slave: one wait state, write takes effect with pready
    // ************************************************************
    acc   = apb_req_in.psel & apb_req_in.penable;
    ofs   = apb_req_in.paddr[4:0];
    ci    = apb_req_in.paddr[DMC_CH_SEL_BIT];
    is_ch = apb_req_in.paddr < DMC_CH_END;
    if (apb_req_in.paddr[1:0] == 2'b00) begin
      if (is_ch) begin
        hit = 1'b1;
        case (ofs)
          DMC_OFS_CTRL: rdv = 32'(r.ch[ci].ctrl);
          DMC_OFS_SRC:  rdv = {16'h0, r.ch[ci].src};
          DMC_OFS_DST:  rdv = {16'h0, r.ch[ci].dst};
          DMC_OFS_BLK:  rdv = {16'h0, r.ch[ci].blksz};
          DMC_OFS_REP:  rdv = {24'h0, r.ch[ci].repcnt};
          DMC_OFS_CUR:  rdv = {r.ch[ci].cur_dst, r.ch[ci].cur_src};
          DMC_OFS_CNT:  rdv = {5'h0, r.ch[ci].swblk, r.ch[ci].pend, r.ch[ci].rep_left,
                               r.ch[ci].blk_left};
          default:      hit = 1'b0;
        endcase
      end else begin
        hit = 1'b1;
        case (apb_req_in.paddr)
          DMC_ADR_PRIO:   rdv = {31'h0, r.prio};
          DMC_ADR_INTST:  rdv = {28'h0, r.int_st};
          DMC_ADR_INTCLR: rdv = '0;
          DMC_ADR_INTEN:  rdv = {28'h0, r.int_en};
          default:        hit = 1'b0;
        endcase
      end
    end
    wr = acc & r.apb.pready & apb_req_in.pwrite & hit;
    if (acc && !r.apb.pready) begin
      n.apb.pready  = 1'b1;
      n.apb.prdata  = apb_req_in.pwrite ? 32'h0 : rdv;
      n.apb.pslverr = ~hit;
    end else begin
      n.apb.pready  = 1'b0;
      n.apb.pslverr = 1'b0;
      n.apb.prdata  = '0;
    end

    // Each channel keeps its own settings, written independently
    if (wr && is_ch) begin
      case (ofs)
        DMC_OFS_CTRL: begin
          n.ch[ci].ctrl = dmc_ctrl_t'(apb_req_in.pwdata[15:0]);
          if (apb_req_in.pwdata[0] && !r.ch[ci].ctrl.en) begin
            n.ch[ci]       = dmc_load(n.ch[ci]);
            n.ch[ci].pend  = 1'b0;
            n.ch[ci].swblk = 1'b0;
          end
          // Software trigger runs a whole block
          if (apb_req_in.pwdata[0] && apb_req_in.pwdata[DMC_SWTRIG_BIT]) begin
            n.ch[ci].pend  = 1'b1;
            n.ch[ci].swblk = 1'b1;
          end
          if (!apb_req_in.pwdata[0]) begin
            n.ch[ci].pend  = 1'b0;
            n.ch[ci].swblk = 1'b0;
          end
        end
        DMC_OFS_SRC: n.ch[ci].src    = apb_req_in.pwdata[15:0];
        DMC_OFS_DST: n.ch[ci].dst    = apb_req_in.pwdata[15:0];
        DMC_OFS_BLK: n.ch[ci].blksz  = apb_req_in.pwdata[15:0];
        DMC_OFS_REP: n.ch[ci].repcnt = apb_req_in.pwdata[7:0];
        default: ;
      endcase
    end
    if (wr && !is_ch) begin
      case (apb_req_in.paddr)
        DMC_ADR_PRIO:   n.prio   = apb_req_in.pwdata[0];
        DMC_ADR_INTCLR: st_clr   = apb_req_in.pwdata[3:0];
        DMC_ADR_INTEN:  n.int_en = apb_req_in.pwdata[3:0];
        default: ;
      endcase
    end

    // ************************************************************
    // Hardware triggers: a request or event arms one burst
    // ************************************************************
    for (int c = 0; c < DMC_NCH; c++) begin
      if (n.ch[c].ctrl.en &&
          (((n.ch[c].ctrl.trig == DMC_TRIG_PERIPH) && periph_req_in[c]) ||
           ((n.ch[c].ctrl.trig == DMC_TRIG_EVENT) && event_in[c]))) begin
        n.ch[c].pend = 1'b1;
      end
    end

    // ************************************************************
    // Transfer engine: read a byte, then write it
    // ************************************************************
    // Reads are held until the memory answers, so the 1, 2 or 3 cycle
    // latencies of I/O, SRAM and mapped EEPROM are all served alike.
    unique case (r.fsm)
      DMC_S_IDLE: begin
        rdy0 = r.ch[0].ctrl.en & r.ch[0].pend;
        rdy1 = r.ch[1].ctrl.en & r.ch[1].pend;
        if (rdy0 || rdy1) begin
          // Arbitration only between bursts keeps each burst unbroken
          if (rdy0 && rdy1) begin
            c_sel = r.prio ? ~r.rr_last : 1'b0;
          end else begin
            c_sel = rdy1;
          end
          n.act     = c_sel;
          n.rr_last = c_sel;
          blen      = 4'(4'h1 << r.ch[c_sel].ctrl.burst);
          n.bcnt    = (r.ch[c_sel].blk_left < 17'(blen)) ?
                      r.ch[c_sel].blk_left[3:0] : blen;
          n.fsm       = DMC_S_RD;
          n.mem.req   = 1'b1;
          n.mem.we    = 1'b0;
          n.mem.addr  = r.ch[c_sel].cur_src;
        end
      end
      DMC_S_RD: begin
        if (mem_rsp_in.rvalid) begin
          if (mem_rsp_in.err) begin
            n.mem.req          = 1'b0;
            n.fsm              = DMC_S_IDLE;
            n.ch[a].ctrl.en    = 1'b0;
            n.ch[a].pend       = 1'b0;
            n.ch[a].swblk      = 1'b0;
            st_set[DMC_ST_ERR + int'(a)] = 1'b1;
          end else begin
            n.data      = mem_rsp_in.rdata;
            n.fsm       = DMC_S_WR;
            n.mem.req   = 1'b1;
            n.mem.we    = 1'b1;
            n.mem.addr  = r.ch[a].cur_dst;
            n.mem.wdata = mem_rsp_in.rdata;
          end
        end
      end
      DMC_S_WR: begin
        // A write occupies exactly one cycle on the bus
        n.mem.req = 1'b0;
        n.mem.we  = 1'b0;
        if (mem_rsp_in.err) begin
          n.fsm           = DMC_S_IDLE;
          n.ch[a].ctrl.en = 1'b0;
          n.ch[a].pend    = 1'b0;
          n.ch[a].swblk   = 1'b0;
          st_set[DMC_ST_ERR + int'(a)] = 1'b1;
        end else begin
          n.crc.valid = r.ch[a].ctrl.crc;
          n.crc.data  = r.data;
          burst_end = r.bcnt == 4'h1;
          blk_end   = r.ch[a].blk_left == 17'h1;
          trans_end = blk_end && (!r.ch[a].ctrl.rep || (r.ch[a].rep_left == 8'h1));
          n.bcnt    = r.bcnt - 4'h1;
          n.ch[a].cur_src = dmc_step(r.ch[a].cur_src, r.ch[a].ctrl.smode);
          n.ch[a].cur_dst = dmc_step(r.ch[a].cur_dst, r.ch[a].ctrl.dmode);
          if (dmc_rl(r.ch[a].ctrl.sreload, burst_end, blk_end, trans_end)) begin
            n.ch[a].cur_src = r.ch[a].src;
          end
          if (dmc_rl(r.ch[a].ctrl.dreload, burst_end, blk_end, trans_end)) begin
            n.ch[a].cur_dst = r.ch[a].dst;
          end
          if (blk_end) begin
            n.ch[a].blk_left = (r.ch[a].blksz == 16'h0) ? DMC_BLK_MAX :
                               {1'b0, r.ch[a].blksz};
            if (r.ch[a].ctrl.rep && (r.ch[a].rep_left != 8'h0)) begin
              n.ch[a].rep_left = r.ch[a].rep_left - 8'h1;
            end
          end else begin
            n.ch[a].blk_left = r.ch[a].blk_left - 17'h1;
          end
          if (burst_end) begin
            n.fsm = DMC_S_IDLE;
            if (!r.ch[a].swblk || blk_end) begin
              n.ch[a].pend = 1'b0;
            end
            if (blk_end) begin
              n.ch[a].swblk = 1'b0;
            end
          end else begin
            n.fsm      = DMC_S_RD;
            n.mem.req  = 1'b1;
            n.mem.addr = n.ch[a].cur_src;
          end
          if (trans_end) begin
            n.ch[a].ctrl.en = 1'b0;
            n.ch[a].pend    = 1'b0;
            st_set[DMC_ST_DONE + int'(a)] = 1'b1;
            if (r.ch[a].ctrl.link) begin
              n.ch[~a]          = dmc_load(n.ch[~a]);
              n.ch[~a].ctrl.en  = 1'b1;
              n.ch[~a].pend     = 1'b1;
              n.ch[~a].swblk    = 1'b1;
            end
          end
        end
      end
      default: n.fsm = DMC_S_IDLE;
    endcase

    // ************************************************************
    // Interrupts: a new event wins over a clear in the same cycle
    // ************************************************************
    n.int_st = (r.int_st & ~st_clr) | st_set;
    n.irq    = |(n.int_st & n.int_en);
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      r <= DMC_STATE_RST;
    end else begin
      r <= n;
    end
  end

  assign apb_rsp_out = r.apb;
  assign mem_req_out = r.mem;
  assign crc_out     = r.crc;
  assign irq_out     = r.irq;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking dmc_cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  burst_len_a: assert property (r.fsm == DMC_S_IDLE && n.fsm == DMC_S_RD |=>
    (r.bcnt != 4'h0) && (r.bcnt <= 4'h8))
    else $error("burst length out of range");
  burst_whole_a: assert property ((r.fsm == DMC_S_WR) && !mem_rsp_in.err &&
    (r.bcnt > 4'h1) |=> (r.fsm == DMC_S_RD) && (r.act == $past(r.act)))
    else $error("burst broken before its last byte");
  incr_addr_a: assert property ((r.fsm == DMC_S_WR) && !mem_rsp_in.err &&
    (r.bcnt > 4'h1) && (r.ch[r.act].ctrl.smode == DMC_AM_INC) &&
    (r.ch[r.act].ctrl.sreload == DMC_RL_NONE)
    |=> r.mem.addr == $past(r.ch[r.act].cur_src) + 16'h1)
    else $error("source address did not increment");
  read_hold_a: assert property ((r.fsm == DMC_S_RD) && !mem_rsp_in.rvalid
    |=> r.mem.req && !r.mem.we && $stable(r.mem.addr))
    else $error("read request dropped before data");
  write_one_a: assert property (r.mem.we |=> !r.mem.we)
    else $error("write held longer than one cycle");
  err_abort_a: assert property (mem_rsp_in.err && ((r.fsm == DMC_S_WR) ||
    ((r.fsm == DMC_S_RD) && mem_rsp_in.rvalid))
    |=> (r.fsm == DMC_S_IDLE) && r.int_st[DMC_ST_ERR + int'($past(r.act))] &&
        !r.ch[$past(r.act)].ctrl.en)
    else $error("bus error did not abort channel");
  done_off_a: assert property ($rose(r.int_st[DMC_ST_DONE]) && !$past(r.ch[1].ctrl.link)
    |-> !r.ch[0].ctrl.en)
    else $error("channel 0 still enabled after completion");
  off_idle_a: assert property ((r.fsm == DMC_S_IDLE) && !r.ch[0].ctrl.en
    |=> !((r.fsm == DMC_S_RD) && (r.act == 1'b0)))
    else $error("disabled channel started a burst");
  irq_done_a: assert property ($rose(r.int_st[DMC_ST_DONE]) && r.int_en[DMC_ST_DONE]
    |-> r.irq)
    else $error("enabled completion raised no interrupt");
  prio_fixed_a: assert property ((r.fsm == DMC_S_IDLE) && !r.prio &&
    r.ch[0].ctrl.en && r.ch[0].pend && r.ch[1].ctrl.en && r.ch[1].pend
    |=> (r.fsm == DMC_S_RD) && (r.act == 1'b0))
    else $error("fixed priority not honoured");
  crc_feed_a: assert property ((r.fsm == DMC_S_WR) && !mem_rsp_in.err &&
    r.ch[r.act].ctrl.crc |=> r.crc.valid && (r.crc.data == $past(r.data)))
    else $error("moved byte not passed to checksum");
  link_go_a: assert property ((r.fsm == DMC_S_WR) && !mem_rsp_in.err && (r.bcnt == 4'h1) &&
    (r.ch[0].blk_left == 17'h1) && (r.act == 1'b0) && !r.ch[0].ctrl.rep &&
    r.ch[0].ctrl.link |=> r.ch[1].ctrl.en && r.ch[1].pend)
    else $error("interlink did not hand over");

  trans_done_c: cover property ($rose(r.int_st[DMC_ST_DONE]));
  error_c:      cover property ($rose(r.int_st[DMC_ST_ERR]));
  burst8_c:     cover property ((r.fsm == DMC_S_RD) && (r.bcnt == 4'h8));
  link_c:       cover property ($rose(r.int_st[DMC_ST_DONE]) && r.ch[1].ctrl.en);

endmodule

//--- verif/dmc_mem_model.sv
// Behavioural data bus: I/O, EEPROM and SRAM regions answering the engine
`timescale 1ns/1ps
module dmc_mem_model
  import dmc_pkg::*;
(
  input  wire logic         sys_clk_in,
  input  wire dmc_mem_req_t req_in,
  input  wire logic [15:0]  err_addr_in,
  input  wire logic         err_en_in,
  output dmc_mem_rsp_t      rsp_out
);
  logic [7:0] mem [0:65535];
  logic [1:0] wait_cnt = '0;
  logic [1:0] lat;
  initial rsp_out = '0;
  // Separate sections, each with its own read latency: 1 cycle below 16'h1000, 3 up to 16'h2000, 2 above
  always_comb begin
    if (req_in.addr < 16'h1000) lat = 2'h1;
    else if (req_in.addr < 16'h2000) lat = 2'h3;
    else lat = 2'h2;
  end
  always @(posedge sys_clk_in) begin
    if (req_in.req && req_in.we) mem[req_in.addr] <= req_in.wdata;
    if (rsp_out.rvalid) begin
      rsp_out <= '{rvalid: 1'b0, err: 1'b0, rdata: ~rsp_out.rdata};
      wait_cnt <= '0;
    end else if (req_in.req && !req_in.we && wait_cnt + 2'h1 == lat) begin
      rsp_out <= '{rvalid: 1'b1, err: err_en_in && req_in.addr == err_addr_in,
                   rdata: mem[req_in.addr]};
    end else if (req_in.req && !req_in.we) begin
      wait_cnt <= wait_cnt + 2'h1;
    end else begin
      // Released data line shows a changing pattern, the last byte and its inverse in turn
      rsp_out.rdata <= ~rsp_out.rdata;
      wait_cnt <= '0;
    end
  end
endmodule

//--- verif/dmc_top_bench.sv
// Self-checking bench of the two-channel DMA controller with a data bus model
`timescale 1ns/1ps
module dmc_top_bench;
  import dmc_pkg::*;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  dmc_apb_req_t apb_req = '0;
  dmc_apb_rsp_t apb_rsp;
  dmc_mem_req_t mreq;
  dmc_mem_rsp_t mrsp;
  dmc_crc_t     crc;
  logic [1:0]   preq = '0;
  logic [1:0]   evt = '0;
  logic         irq;
  logic [15:0]  err_addr = '0;
  logic         err_en = 1'b0;
  logic [15:0]  lfsr = 16'h0041;
  logic [31:0]  rd;
  logic         rerr;
  logic [7:0]   last_wd = '0;
  logic [7:0]   exp_mem [logic [15:0]];
  int           mismatches = 0;
  int           n_compared = 0;
  int           cycles = 0;
  int           crc_cnt = 0;
  dmc_top dmc_top_inst (.sys_clk_in(clk), .sys_rst_in(rst), .apb_req_in(apb_req),
    .apb_rsp_out(apb_rsp), .mem_req_out(mreq), .mem_rsp_in(mrsp), .periph_req_in(preq),
    .event_in(evt), .crc_out(crc), .irq_out(irq));
  dmc_mem_model dmc_mem_model_inst (.sys_clk_in(clk), .req_in(mreq),
    .err_addr_in(err_addr), .err_en_in(err_en), .rsp_out(mrsp));
  always #2 clk = ~clk;
  function automatic logic [15:0] step(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [15:0] nxt(input logic [15:0] a, input logic [1:0] m);
    return (m == DMC_AM_INC) ? a + 16'h1 : (m == DMC_AM_DEC) ? a - 16'h1 : a;
  endfunction
  // Address restore after burst, block or transaction end
  function automatic logic rl(input logic [1:0] sel, input logic be, ke, te);
    return (sel == DMC_RL_BURST && be) || (sel == DMC_RL_BLOCK && ke) ||
           (sel == DMC_RL_TRANS && te);
  endfunction
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard: far above the few thousand cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (crc.valid === 1'b1) begin
      crc_cnt++;
      check({24'h0, crc.data}, {24'h0, last_wd});
    end
    if (mreq.req === 1'b1 && mreq.we === 1'b1) last_wd = mreq.wdata;
    if (cycles == 60000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do @(posedge clk); while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    rerr = apb_rsp.pslverr;
    apb_req <= '0;
  endtask
  task automatic wait_irq(input logic [3:0] st);
    while (irq !== 1'b1) @(posedge clk);
    apb(0, DMC_ADR_INTST, 0);
    check(rd, {28'h0, st});
    apb(1, DMC_ADR_INTCLR, 32'hf);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
  endtask
  task automatic cfg(input int ch, input logic [31:0] ctl, input logic [15:0] s0, d0,
                     input logic [16:0] blk, input int reps);
    logic [7:0] b;
    b = 8'(ch) * DMC_CH_STRIDE;
    apb(1, b + {3'h0, DMC_OFS_SRC}, {16'h0, s0});
    apb(1, b + {3'h0, DMC_OFS_DST}, {16'h0, d0});
    apb(1, b + {3'h0, DMC_OFS_BLK}, {15'h0, blk});
    apb(1, b + {3'h0, DMC_OFS_REP}, 32'(reps));
    apb(1, b, ctl);
  endtask
  task automatic run(input int ch, input logic [31:0] ctl, input logic [15:0] s0, d0,
                     input logic [16:0] blk, input int reps, input logic [3:0] st);
    logic [15:0] s;
    logic [15:0] d;
    logic [7:0]  b;
    int          c0;
    logic        be;
    logic        ke;
    logic        te;
    s = s0;
    d = d0;
    b = 8'(ch) * DMC_CH_STRIDE;
    c0 = crc_cnt;
    exp_mem.delete();
    for (int r = 0; r < reps; r++) begin
      for (int i = 0; i < blk; i++) begin
        exp_mem[d] = dmc_mem_model_inst.mem[s];
        s = nxt(s, ctl[9:8]);
        d = nxt(d, ctl[11:10]);
        be = ((i + 1) % (1 << ctl[4:3]) == 0) || (i + 1 == blk);
        ke = (i + 1 == blk);
        te = ke && (r + 1 == reps);
        if (rl(ctl[13:12], be, ke, te)) s = s0;
        if (rl(ctl[15:14], be, ke, te)) d = d0;
      end
    end
    cfg(ch, ctl | 32'h1 | (ctl[2:1] == DMC_TRIG_SW ? 32'h8000_0000 : 32'h0), s0, d0, blk, reps);
    // A software trigger runs one block, so each repeated block needs a new one
    for (int r = 1; ctl[2:1] == DMC_TRIG_SW && r < reps; r++) begin
      do apb(0, b + {3'h0, DMC_OFS_CNT}, 0); while (rd[25]);
      check({24'h0, rd[24:17]}, 32'(reps - r));
      apb(1, b, ctl | 32'h8000_0001);
    end
    for (int i = blk; ctl[2:1] != DMC_TRIG_SW && i > 0; i--) begin
      apb(0, b + {3'h0, DMC_OFS_CNT}, 0);
      check({15'h0, rd[16:0]}, 32'(i));
      if (ctl[2:1] == DMC_TRIG_PERIPH) preq[ch] <= 1'b1;
      else evt[ch] <= 1'b1;
      @(posedge clk);
      preq <= '0;
      evt <= '0;
      do @(posedge clk); while (!(mreq.req === 1'b1 && mreq.we === 1'b1));
    end
    wait_irq(st);
    apb(0, b, 0);
    check({31'h0, rd[0]}, 32'h0);
    if (st[3:2] == 2'h0) begin
      apb(0, b + {3'h0, DMC_OFS_CUR}, 0);
      check(rd, {d, s});
      foreach (exp_mem[a]) check(dmc_mem_model_inst.mem[a], exp_mem[a]);
      if (ctl[6]) check(crc_cnt - c0, blk * reps);
    end
    $display("transfer on channel %0d finished", ch);
  endtask
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    for (int a = 0; a < 65536; a++) begin
      lfsr = step(lfsr);
      dmc_mem_model_inst.mem[a] = lfsr[7:0];
    end
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 'h50; a += 4) begin
      apb(0, 8'(a), 0);
      check(rd, 32'h0);
      check({31'h0, rerr}, {31'h0, a[4:0] == 5'h1c});
    end
    apb(0, 8'h02, 0);
    check({31'h0, rerr}, 32'h1);
    $display("register map checked");
    apb(1, DMC_ADR_PRIO, 32'h1);
    apb(0, DMC_ADR_PRIO, 0);
    check(rd, 32'h1);
    apb(1, DMC_ADR_INTEN, 32'hf);
    for (int k = 0; k < 8; k++) begin
      lfsr = step(lfsr);
      run(k % 2, {16'h0, lfsr[13:12], lfsr[15:14], 2'(lfsr % 3), 2'(lfsr[7:4] % 3), 3'h2,
                  2'(k % 4), 3'h0},
          16'h0180 + 16'(k % 3) * 16'h1000, 16'h3000 + 16'(k) * 16'h40,
          17'(1 + lfsr[11:8]), 1, 4'(1 << (k % 2)));
    end
    run(0, {18'h0, DMC_RL_BLOCK, 4'h5, 8'h20}, 16'h2400, 16'h3400, 3, 2, 4'h1);
    err_en <= 1'b1;
    err_addr <= 16'h2502;
    run(1, 32'h0500, 16'h2500, 16'h3500, 4, 1, 4'h8);
    err_en <= 1'b0;
    for (int t = 1; t < 3; t++) run(1, 32'h0500 | 32'(t << 1), 16'h2600 + 16'(t * 16),
                                   16'h3600 + 16'(t * 16), 2, 1, 4'h2);
    cfg(1, 32'h0500, 16'h2700, 16'h3700, 5, 1);
    apb(1, DMC_ADR_INTEN, 32'h2);
    run(0, 32'h0580, 16'h2800, 16'h3800, 4, 1, 4'h3);
    // Both channels armed in one cycle under fixed priority
    apb(1, DMC_ADR_PRIO, 32'h0);
    cfg(0, 32'h0505, 16'h2900, 16'h3900, 1, 1);
    cfg(1, 32'h0505, 16'h2a00, 16'h3a00, 1, 1);
    evt <= 2'b11;
    @(posedge clk);
    evt <= 2'b00;
    wait_irq(4'h3);
    check(dmc_mem_model_inst.mem[16'h3900], dmc_mem_model_inst.mem[16'h2900]);
    check(dmc_mem_model_inst.mem[16'h3a00], dmc_mem_model_inst.mem[16'h2a00]);
    $display("simultaneous event pair finished");
    end_of_test();
  end
endmodule
